/* File: fpb_map.svh */
/*
 * register offsets, field layouts, reset values, command codes and timing
 * for the flash protect and byte program block.
 * assumes: included by bare name from the package and the design modules.
 */
`ifndef FPB_MAP_SVH
`define FPB_MAP_SVH

// register file locations
`define FPB_ADDR_FLASH_CTRL   12'hff8
`define FPB_ADDR_SHARED      12'hff9

// flash control command codes
`define FPB_CMD_RESET        8'h00
`define FPB_CMD_PROT_SEL     8'h5e
`define FPB_CMD_UNLOCK_A     8'h3c
`define FPB_CMD_UNLOCK_B     8'hc3
`define FPB_CMD_MASS_ERASE   8'h95
`define FPB_CMD_PAGE_ERASE   8'h96

// reset and erase values
`define FPB_PROTECT_RESET    8'h00
`define FPB_PAGE_SEL_RESET   8'h00
`define FPB_ERASED_BYTE      8'hff

// memory layout: 4096 bytes, 8 sectors of 512 bytes, one page per sector
`define FPB_MEM_BYTES        4096
`define FPB_ADDR_W           12
`define FPB_PAGE_MSB         11
`define FPB_PAGE_LSB         9
`define FPB_SECTORS          8

// status read at the control location: {busy, prot_sel, 3'h0, lock state}
`define FPB_STAT_BUSY_BIT    7
`define FPB_STAT_SEL_BIT     6

// byte program time
`define FPB_CLK_PERIOD_NS    25
`define FPB_PROG_TIME_NS     1000
`define FPB_PROG_CYCLES      ((`FPB_PROG_TIME_NS + `FPB_CLK_PERIOD_NS - 1) / `FPB_CLK_PERIOD_NS)
`define FPB_CNT_W            6

`endif

/* File: fpb_pkg.sv */
/*
 * types shared by the flash protect and byte program block.
 * assumes: fpb_map.svh is on the include path.
 */
`include "fpb_map.svh"

package fpb_pkg;

    // unlock and erase-enable progress of the controller
    typedef enum logic [2:0] {
        FPB_LOCKED    = 3'b000,
        FPB_UNLOCK_1  = 3'b001,
        FPB_UNLOCKED  = 3'b010,
        FPB_MASS_EN   = 3'b011,
        FPB_PAGE_EN   = 3'b100
    } fpb_lock_t;

    // byte program engine
    typedef enum logic {
        FPB_IDLE = 1'b0,
        FPB_BUSY = 1'b1
    } fpb_prog_t;

    // register file access
    typedef struct packed {
        logic                      wr;
        logic                      rd;
        logic [`FPB_ADDR_W-1:0]    addr;
        logic [7:0]                wdata;
    } fpb_rf_req_t;

    // byte program request from core store or debugger memory write
    typedef struct packed {
        logic                      req;
        logic [`FPB_ADDR_W-1:0]    addr;
        logic [7:0]                data;
    } fpb_prog_req_t;

endpackage

/* File: fpb_access_check.sv */
/*
 * decides whether a byte program at an address is allowed right now.
 * assumes: all inputs come from flip-flops on the same clock; purely combinational.
 */
`include "fpb_map.svh"

module fpb_access_check (
    // controller state
    input  wire fpb_pkg::fpb_lock_t       lock_state,
    input  wire logic [2:0]               page_sel,
    input  wire logic [`FPB_SECTORS-1:0]  protect,
    // target
    input  wire logic [`FPB_ADDR_W-1:0]   addr,
    // verdict
    output logic                          allow
);

    logic [2:0] sector;

    assign sector = addr[`FPB_PAGE_MSB:`FPB_PAGE_LSB];

    // mode gate, then page window, then sector protection
    always_comb begin
        allow = 1'b0;
        unique case (lock_state)
            fpb_pkg::FPB_MASS_EN: allow = 1'b1;
            fpb_pkg::FPB_PAGE_EN: allow = (sector == page_sel);
            default:              allow = 1'b0;
        endcase
        if (protect[sector]) begin
            allow = 1'b0;
        end
    end

endmodule

/* File: fpb_byte_array.sv */
/*
 * flash byte storage held in flip-flops, with per-sector erase and
 * program-only-clears writes, plus one registered read port.
 * assumes: erase and write are never requested for the same byte in one cycle;
 * contents are not touched by reset, like the real array.
 */
`include "fpb_map.svh"

module fpb_byte_array (
    // clock
    input  wire logic                      clk,
    input  wire logic                      ce,
    // erase and program
    input  wire logic [`FPB_SECTORS-1:0]   erase_sector,
    input  wire logic                      wr_en,
    input  wire logic [`FPB_ADDR_W-1:0]    wr_addr,
    input  wire logic [7:0]                wr_data,
    // read
    input  wire logic [`FPB_ADDR_W-1:0]    rd_addr,
    output logic [7:0]                     rd_data_ff
);

    logic [7:0] mem_ff [`FPB_MEM_BYTES];

    // one process per byte; an erase wins, a program can only pull bits low
    for (genvar i = 0; i < `FPB_MEM_BYTES; i++) begin : g_byte
        always_ff @(posedge clk) begin
            if (ce) begin
                if (erase_sector[i / 512]) begin
                    mem_ff[i] <= `FPB_ERASED_BYTE;
                end else if (wr_en && (wr_addr == 12'(i))) begin
                    mem_ff[i] <= mem_ff[i] & wr_data;
                end
            end
        end
    end

    // registered read port
    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end

endmodule

/* File: fpb_flash_ctrl.sv */
/*
 * flash protect and byte program controller: flash control register,
 * sector protect / page select shared location, unlock and erase-enable
 * tracking, byte program engine that idles the core while it runs.
 * assumes: register file and program requests come from logic on clk;
 * reset is synchronous active high; ce low freezes everything except the outcome pulses, which are cleared.
 */
//
// Behaviour
// - protect bits are set by writing one; a written zero leaves them unchanged.
// - any control write other than 5eh deselects protect and restores page select.
// - after 5eh, the protect register is read and written at ff9h.
// - writing 00h to the control register relocks and deselects protect; protect and page select keep their values.
// - reset clears the protect register, leaving every sector unprotected.
// - program or erase aimed at a protected sector is refused.
// - byte programming needs unlock plus a successful mass or page erase enable.
// - unlocked with mass erase enabled, every unprotected location may be programmed.
// - unlocked with page erase enabled, only the selected page may be programmed.
// - an erased byte reads back as ffh.
// - programming only clears bits; setting bits back needs an erase.
// - the core is held idle while a byte programs; clock keeps running.
// - a control write other than mass or page erase ends programming and relocks.
`include "fpb_map.svh"

module fpb_flash_ctrl (
    // clock and reset
    clk,
    rst,
    ce,
    // register file
    rf,
    rf_rdata_ff,
    // byte program requests
    prog,
    cpu_idle_ff,
    prog_done_ff,
    prog_refused_ff,
    // program memory read
    mem_raddr,
    mem_rdata_ff,
    // status
    protect_ff
);
    input  wire logic                       clk;
    input  wire logic                       rst;
    input  wire logic                       ce;
    input  wire fpb_pkg::fpb_rf_req_t       rf;
    output logic [7:0]                      rf_rdata_ff;
    input  wire fpb_pkg::fpb_prog_req_t     prog;
    output logic                            cpu_idle_ff;
    output logic                            prog_done_ff;
    output logic                            prog_refused_ff;
    input  wire logic [`FPB_ADDR_W-1:0]     mem_raddr;
    output logic [7:0]                      mem_rdata_ff;
    output logic [`FPB_SECTORS-1:0]         protect_ff;

    fpb_pkg::fpb_lock_t      lock_ff;
    fpb_pkg::fpb_lock_t      nxt_lock;
    fpb_pkg::fpb_prog_t      state_ff;
    logic                    prot_sel_ff;
    logic [2:0]              page_sel_ff;
    logic [`FPB_CNT_W-1:0]   cnt_ff;
    logic                    ctrl_wr;
    logic                    shared_wr;
    logic                    allow;
    logic                    take;
    logic                    accept;
    logic                    page_prot;
    logic [`FPB_SECTORS-1:0] erase_sector;

    // strobe decode, same cycle as the write
    assign ctrl_wr   = rf.wr && (rf.addr == `FPB_ADDR_FLASH_CTRL);
    assign shared_wr = rf.wr && (rf.addr == `FPB_ADDR_SHARED);
    assign page_prot = protect_ff[page_sel_ff];
    // requests are only taken while idle, so a second one cannot overlap
    assign take      = prog.req && (state_ff == fpb_pkg::FPB_IDLE);
    assign accept    = take && allow;

    fpb_access_check u_check (
        .lock_state (lock_ff),
        .page_sel   (page_sel_ff),
        .protect    (protect_ff),
        .addr       (prog.addr),
        .allow      (allow)
    );

    // erases strike unprotected sectors only; mass erase skips protected ones
    always_comb begin
        erase_sector = '0;
        if (ctrl_wr && (lock_ff == fpb_pkg::FPB_UNLOCKED)) begin
            if (rf.wdata == `FPB_CMD_MASS_ERASE) begin
                erase_sector = ~protect_ff;
            end else if ((rf.wdata == `FPB_CMD_PAGE_ERASE) && !page_prot) begin
                erase_sector = 8'(1) << page_sel_ff;
            end
        end
    end

    fpb_byte_array u_array (
        .clk          (clk),
        .ce           (ce),
        .erase_sector (erase_sector),
        .wr_en        (accept),
        .wr_addr      (prog.addr),
        .wr_data      (prog.data),
        .rd_addr      (mem_raddr),
        .rd_data_ff   (mem_rdata_ff)
    );

    // unlock and erase enable sequence; a refused page erase is not a success
    always_comb begin
        nxt_lock = lock_ff;
        if (ctrl_wr) begin
            nxt_lock = fpb_pkg::FPB_LOCKED;
            unique case (lock_ff)
                fpb_pkg::FPB_LOCKED: begin
                    if (rf.wdata == `FPB_CMD_UNLOCK_A) begin
                        nxt_lock = fpb_pkg::FPB_UNLOCK_1;
                    end
                end
                fpb_pkg::FPB_UNLOCK_1: begin
                    if (rf.wdata == `FPB_CMD_UNLOCK_B) begin
                        nxt_lock = fpb_pkg::FPB_UNLOCKED;
                    end
                end
                fpb_pkg::FPB_UNLOCKED, fpb_pkg::FPB_MASS_EN, fpb_pkg::FPB_PAGE_EN: begin
                    if (rf.wdata == `FPB_CMD_MASS_ERASE) begin
                        nxt_lock = fpb_pkg::FPB_MASS_EN;
                    end else if ((rf.wdata == `FPB_CMD_PAGE_ERASE) && !page_prot) begin
                        nxt_lock = fpb_pkg::FPB_PAGE_EN;
                    end
                end
                default: nxt_lock = fpb_pkg::FPB_LOCKED;
            endcase
            if (rf.wdata == `FPB_CMD_RESET) begin
                nxt_lock = fpb_pkg::FPB_LOCKED;
            end
        end
    end

    // lock state register
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_ff <= fpb_pkg::FPB_LOCKED;
        end else if (ce) begin
            lock_ff <= nxt_lock;
        end
    end

    // protect select flag: only 5eh selects, any other control write drops it
    always_ff @(posedge clk) begin
        if (rst) begin
            prot_sel_ff <= 1'b0;
        end else if (ce && ctrl_wr) begin
            prot_sel_ff <= (rf.wdata == `FPB_CMD_PROT_SEL);
        end
    end

    // sector protect: set-only, cleared by reset alone
    always_ff @(posedge clk) begin
        if (rst) begin
            protect_ff <= `FPB_PROTECT_RESET;
        end else if (ce && shared_wr && prot_sel_ff) begin
            protect_ff <= protect_ff | rf.wdata;
        end
    end

    // page select shares the location while protect is not selected
    always_ff @(posedge clk) begin
        if (rst) begin
            page_sel_ff <= 3'(`FPB_PAGE_SEL_RESET);
        end else if (ce && shared_wr && !prot_sel_ff) begin
            page_sel_ff <= rf.wdata[2:0];
        end
    end

    // register read port, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rf_rdata_ff <= 8'h00;
        end else if (ce && rf.rd) begin
            if (rf.addr == `FPB_ADDR_SHARED) begin
                rf_rdata_ff <= prot_sel_ff ? protect_ff : {5'h00, page_sel_ff};
            end else if (rf.addr == `FPB_ADDR_FLASH_CTRL) begin
                rf_rdata_ff <= {state_ff == fpb_pkg::FPB_BUSY, prot_sel_ff, 3'h0, lock_ff};
            end else begin
                rf_rdata_ff <= 8'h00;
            end
        end
    end

    // program engine: core idles for the program time, clock keeps running
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff    <= fpb_pkg::FPB_IDLE;
            cnt_ff      <= '0;
            cpu_idle_ff <= 1'b0;
        end else if (ce) begin
            unique case (state_ff)
                fpb_pkg::FPB_IDLE: begin
                    if (accept) begin
                        state_ff    <= fpb_pkg::FPB_BUSY;
                        cnt_ff      <= `FPB_CNT_W'(`FPB_PROG_CYCLES - 1);
                        cpu_idle_ff <= 1'b1;
                    end
                end
                fpb_pkg::FPB_BUSY: begin
                    if (cnt_ff == '0) begin
                        state_ff    <= fpb_pkg::FPB_IDLE;
                        cpu_idle_ff <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff - `FPB_CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // one-cycle outcome pulses; a refusal never touches the hold
    always_ff @(posedge clk) begin
        if (rst) begin
            prog_done_ff    <= 1'b0;
            prog_refused_ff <= 1'b0;
        end else if (ce) begin
            prog_done_ff    <= (state_ff == fpb_pkg::FPB_BUSY) && (cnt_ff == '0);
            prog_refused_ff <= take && !allow;
        end else begin
            prog_done_ff    <= 1'b0;
            prog_refused_ff <= 1'b0;
        end
    end

    // checks
    property p_protect_sticky;
        @(posedge clk) disable iff (rst)
        ce |=> (protect_ff & $past(protect_ff)) == $past(protect_ff);
    endproperty
    a_protect_sticky: assert property (p_protect_sticky) else $error("protect bit cleared");

    property p_sel_drop;
        @(posedge clk) disable iff (rst)
        (ce && ctrl_wr && rf.wdata != `FPB_CMD_PROT_SEL) |=> !prot_sel_ff;
    endproperty
    a_sel_drop: assert property (p_sel_drop) else $error("protect stayed selected");

    property p_read_shared;
        @(posedge clk) disable iff (rst)
        (ce && rf.rd && rf.addr == `FPB_ADDR_SHARED && prot_sel_ff) |=> rf_rdata_ff == $past(protect_ff);
    endproperty
    a_read_shared: assert property (p_read_shared) else $error("protect not read at shared location");

    property p_zero_reset;
        @(posedge clk) disable iff (rst)
        (ce && ctrl_wr && rf.wdata == `FPB_CMD_RESET) |=> lock_ff == fpb_pkg::FPB_LOCKED && !prot_sel_ff;
    endproperty
    a_zero_reset: assert property (p_zero_reset) else $error("00h did not reset controller");

    property p_reset_clear;
        @(posedge clk) rst |=> protect_ff == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("protect not cleared by reset");

    property p_protect_refuse;
        @(posedge clk) disable iff (rst)
        (ce && take && protect_ff[prog.addr[`FPB_PAGE_MSB:`FPB_PAGE_LSB]]) |=> prog_refused_ff && !cpu_idle_ff;
    endproperty
    a_protect_refuse: assert property (p_protect_refuse) else $error("protected sector programmed");

    property p_locked_refuse;
        @(posedge clk) disable iff (rst)
        (ce && take && lock_ff != fpb_pkg::FPB_MASS_EN && lock_ff != fpb_pkg::FPB_PAGE_EN) |=> prog_refused_ff;
    endproperty
    a_locked_refuse: assert property (p_locked_refuse) else $error("program accepted while locked");

    property p_page_window;
        @(posedge clk) disable iff (rst)
        (ce && take && lock_ff == fpb_pkg::FPB_PAGE_EN
            && prog.addr[`FPB_PAGE_MSB:`FPB_PAGE_LSB] != page_sel_ff) |=> prog_refused_ff;
    endproperty
    a_page_window: assert property (p_page_window) else $error("program outside selected page");

    property p_hold_time;
        @(posedge clk) disable iff (rst || !ce)
        (ce && accept) |=> cpu_idle_ff [*8];
    endproperty
    a_hold_time: assert property (p_hold_time) else $error("core hold ended early");

    property p_relock;
        @(posedge clk) disable iff (rst)
        (ce && ctrl_wr && rf.wdata != `FPB_CMD_MASS_ERASE && rf.wdata != `FPB_CMD_PAGE_ERASE)
            |=> lock_ff != fpb_pkg::FPB_MASS_EN && lock_ff != fpb_pkg::FPB_PAGE_EN;
    endproperty
    a_relock: assert property (p_relock) else $error("programming mode survived control write");

    property p_done_end;
        @(posedge clk) disable iff (rst)
        (ce && state_ff == fpb_pkg::FPB_BUSY && cnt_ff == '0) |=> prog_done_ff && !cpu_idle_ff;
    endproperty
    a_done_end: assert property (p_done_end) else $error("program end not signalled");

    property p_page_write;
        @(posedge clk) disable iff (rst)
        (ce && shared_wr && !prot_sel_ff) |=> page_sel_ff == $past(rf.wdata[2:0]);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page select not written");

endmodule

/* File: fpb_req_model.sv */
/*
 * requester model: a core or debugger that writes and reads the register
 * file and starts byte programs by program-memory stores.
 * assumes: requests change just after the falling edge, the design samples on the rising edge.
 */
module fpb_req_model (
    // clock
    input  wire logic                clk,
    // requests towards the controller
    output fpb_pkg::fpb_rf_req_t     rf,
    output fpb_pkg::fpb_prog_req_t   prog
);
    timeunit 1ns;
    timeprecision 1ps;

    // nothing requested at time zero
    initial begin
        rf = '0;
        prog = '0;
    end

    // one register access; released lines show the inverse so stale values never match
    task automatic rf_access(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        rf.wr = wr;
        rf.rd = ~wr;
        rf.addr = a;
        rf.wdata = d;
        @(negedge clk);
        rf.wr = 1'b0;
        rf.rd = 1'b0;
        rf.addr = ~a;
        rf.wdata = ~d;
    endtask

    // a store through load_program_memory_instr or its auto-increment form
    task automatic prog_byte(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        prog.req = 1'b1;
        prog.addr = a;
        prog.data = d;
        @(negedge clk);
        prog.req = 1'b0;
        prog.addr = ~a;
        prog.data = ~d;
    endtask
endmodule

/* File: flash_protect_and_byte_program_tb_top.sv */
/*
 * self-checking bench for the flash protect and byte program controller.
 * assumes: fpb_pkg and the design files are compiled first; one 40 MHz clock.
 */
`include "fpb_map.svh"

module flash_protect_and_byte_program_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     ce = 1'b1;
    logic [11:0]              mem_raddr = 12'h000;
    fpb_pkg::fpb_rf_req_t     rf;
    fpb_pkg::fpb_prog_req_t   prog;
    logic [7:0]               rf_rdata_ff;
    logic                     cpu_idle_ff;
    logic                     prog_done_ff;
    logic                     prog_refused_ff;
    logic [7:0]               mem_rdata_ff;
    logic [7:0]               protect_ff;
    int                       n_errors = 0;
    int                       samples_checked = 0;
    int                       cycles = 0;
    logic [15:0]              seed = 16'h000f;

    // 25 ns clock
    always #12.5 clk = ~clk;

    fpb_req_model i_req (
        .clk  (clk),
        .rf   (rf),
        .prog (prog)
    );

    fpb_flash_ctrl i_dut (
        .clk             (clk),
        .rst             (rst),
        .ce              (ce),
        .rf              (rf),
        .rf_rdata_ff     (rf_rdata_ff),
        .prog            (prog),
        .cpu_idle_ff     (cpu_idle_ff),
        .prog_done_ff    (prog_done_ff),
        .prog_refused_ff (prog_refused_ff),
        .mem_raddr       (mem_raddr),
        .mem_rdata_ff    (mem_rdata_ff),
        .protect_ff      (protect_ff)
    );

    // 16-bit lfsr, taps 16 14 13 11
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // programming can only clear bits
    function automatic logic [7:0] prog_result(input logic [7:0] old, input logic [7:0] d);
        return old & d;
    endfunction

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic ctl(input logic [7:0] d);
        i_req.rf_access(1'b1, 12'hff8, d);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] exp);
        i_req.rf_access(1'b0, a, 8'h00);
        check(nm, {4'h0, rf_rdata_ff}, {4'h0, exp});
    endtask

    task automatic lock_chk(input logic [2:0] exp);
        i_req.rf_access(1'b0, 12'hff8, 8'h00);
        check("lock", {9'h0, rf_rdata_ff[2:0]}, {9'h0, exp});
    endtask

    task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
        @(negedge clk);
        mem_raddr = a;
        @(negedge clk);
        check("mem", {4'h0, mem_rdata_ff}, {4'h0, exp});
    endtask

    // one program request; an accepted one holds the core for the whole program time
    task automatic prog_chk(input logic [11:0] a, input logic [7:0] d, input logic ok);
        int n;
        n = 0;
        i_req.prog_byte(a, d);
        check("refused", {11'h0, prog_refused_ff}, {11'h0, ~ok});
        check("idle", {11'h0, cpu_idle_ff}, {11'h0, ok});
        while (ok && prog_done_ff !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (ok) begin
            check("prog_cycles", 12'(n), 12'(`FPB_PROG_CYCLES));
            check("done", {11'h0, prog_done_ff}, 12'h001);
            check("idle_end", {11'h0, cpu_idle_ff}, 12'h000);
        end
    endtask

    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  d2;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check("protect_rst", {4'h0, protect_ff}, 12'h000);
        ctl(8'h00);
        ctl(8'h5e);
        rd_chk("status", 12'hff8, 8'h40);
        rd_chk("protect_rd", 12'hff9, 8'h00);
        i_req.rf_access(1'b1, 12'hff9, 8'h80);
        check("protect", {4'h0, protect_ff}, 12'h080);
        i_req.rf_access(1'b1, 12'hff9, 8'h01);
        check("protect", {4'h0, protect_ff}, 12'h081);
        i_req.rf_access(1'b1, 12'hff9, 8'h00);
        rd_chk("protect_rd", 12'hff9, 8'h81);
        ctl(8'h00);
        i_req.rf_access(1'b1, 12'hff9, 8'h03);
        rd_chk("page_sel", 12'hff9, 8'h03);
        check("protect", {4'h0, protect_ff}, 12'h081);
        rd_chk("unmapped", 12'h123, 8'h00);
        prog_chk(12'h2a5, 8'h00, 1'b0);
        ctl(8'h3c);
        ctl(8'hc3);
        lock_chk(3'd2);
        prog_chk(12'h2a5, 8'h00, 1'b0);
        ctl(8'h95);
        lock_chk(3'd3);
        mem_chk(12'h2a5, 8'hff);
        prog_chk(12'h2a5, 8'h5a, 1'b1);
        mem_chk(12'h2a5, 8'h5a);
        // random bytes in the erased, unprotected sectors 1 to 5; one slot per pass keeps
        // every address distinct, so no byte is programmed more than twice
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            a = 12'h300 + 12'(i) * 12'h180 + 12'(seed % 16'h0180);
            seed = lfsr_next(seed);
            d = seed[7:0];
            d2 = seed[15:8];
            mem_chk(a, 8'hff);
            prog_chk(a, d, 1'b1);
            prog_chk(a, d2, 1'b1);
            mem_chk(a, prog_result(d, d2));
        end
        prog_chk(12'h005, 8'h00, 1'b0);
        ctl(8'h00);
        lock_chk(3'd0);
        prog_chk(12'h2a5, 8'h00, 1'b0);
        mem_chk(12'h2a5, 8'h5a);
        ctl(8'h3c);
        ctl(8'hc3);
        ctl(8'h96);
        lock_chk(3'd4);
        mem_chk(12'h6c3, 8'hff);
        prog_chk(12'h6c3, 8'ha7, 1'b1);
        mem_chk(12'h6c3, 8'ha7);
        prog_chk(12'h2a5, 8'h00, 1'b0);
        mem_chk(12'h2a5, 8'h5a);
        ctl(8'h00);
        i_req.rf_access(1'b1, 12'hff9, 8'h07);
        ctl(8'h3c);
        ctl(8'hc3);
        ctl(8'h96);
        lock_chk(3'd0);
        // a frozen clock enable must swallow a shared location write
        @(negedge clk);
        ce = 1'b0;
        i_req.rf_access(1'b1, 12'hff9, 8'h05);
        @(negedge clk);
        ce = 1'b1;
        rd_chk("ce_freeze", 12'hff9, 8'h07);
        // second reset in mid-run clears protection and page select again
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check("protect_rst2", {4'h0, protect_ff}, 12'h000);
        rd_chk("page_sel_rst", 12'hff9, 8'h00);
        lock_chk(3'd0);
        stop_test();
    end
endmodule
